// [hw/eot_pkg.sv]
// eot_pkg: constants for the enhanced opcode trap block.
// assumes a 20 MHz core_clk_i; break times are counted on that clock.
package eot_pkg;
	localparam int unsigned CLK_HZ         = 20000000;
	// break times in microseconds, figures as printed
	localparam int unsigned T_WORD_MOVE_US = 3400;
	localparam int unsigned T_LOAD_US      = 3600;
	localparam int unsigned T_LOAD_INC_US  = 3800;
	localparam int unsigned T_ELOAD_US     = 4600;
	localparam int unsigned T_ELOAD_INC_US = 4900;
	localparam int unsigned T_MUL_US       = 5800;
	localparam int unsigned T_SPM_IGN_US   = 1100;
	localparam int unsigned T_ADDR0_US     = 800;
	localparam int unsigned T_SPM1_US      = 5700;
	localparam int unsigned T_SPM3_US      = 11500;
	localparam int unsigned T_SPM5_US      = 26800;
	localparam int unsigned T_SPM9_US      = 2400;
	localparam int unsigned CYC_PER_US     = CLK_HZ / 1000000;

	// opcode class codes from the decoder
	typedef enum logic [3:0] {
		EOT_OP_NONE      = 4'h0,
		EOT_OP_WMOVE     = 4'h1,
		EOT_OP_LOAD0     = 4'h2,
		EOT_OP_LOAD      = 4'h3,
		EOT_OP_LOAD_INC  = 4'h4,
		EOT_OP_ELOAD0    = 4'h5,
		EOT_OP_ELOAD     = 4'h6,
		EOT_OP_ELOAD_INC = 4'h7,
		EOT_OP_MUL       = 4'h8,
		EOT_OP_SPM       = 4'h9
	} eot_op_t;

	typedef enum logic [1:0] {
		EOT_ST_RUN   = 2'h0,
		EOT_ST_BREAK = 2'h1,
		EOT_ST_WAIT  = 2'h2
	} eot_state_t;

	localparam logic [15:0] ADDR_ZERO    = 16'h0000;
	localparam logic [7:0]  SPM_CTL_ERASE = 8'h03;
	localparam logic [7:0]  SPM_CTL_WRITE = 8'h05;
	localparam logic [7:0]  SPM_CTL_LOCK  = 8'h09;
	localparam logic [7:0]  SPM_CTL_FILL  = 8'h01;
	localparam int unsigned VEC_WORDS     = 2;

	// APB map
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_MASK   = 8'h08;
	localparam logic [7:0] REG_CAUSE  = 8'h0C;
	localparam int unsigned CTRL_ENH      = 0;
	localparam int unsigned CTRL_BOOTRSTF = 1;
	localparam int unsigned CTRL_NOENHDEV = 2;
	localparam int unsigned CTRL_DONE     = 3;
	localparam int unsigned ST_BREAK = 0;
	localparam int unsigned ST_WARN  = 1;
	localparam int unsigned ST_ADDR0 = 2;
	localparam int unsigned ST_BITS  = 3;
	localparam logic [2:0] CTRL_RESET = 3'h2;
endpackage : eot_pkg

// [hw/eot_trap.sv]
// eot_trap: halts the core on trapped opcodes and at address zero,
// freezes the peripheral clock and times the break in core_clk_i cycles.
// assumes opcode class and pc come from decode logic on core_clk_i.
// Summary of operation
// - enhanced option on: trapped opcode halts core until supervisor finishes it.
// - word move 3,4 ms; load 3,6 ms; post-increment load 3,8 ms.
// - extended load 4,6 ms, post-increment 4,9 ms; every multiply 5,8 ms.
// - break lengths are counted on a fixed clock, not the target clock; here they are counted on core_clk_i, the target core clock.
// - boot-reset fuse at 0 breaks at address zero for about 0,8 ms.
// - peripheral I/O clock stopped for the whole break.
// - external data memory access takes one extra internal cycle.
// - operand-free loads run without break while enhanced option is off.
// - lock and fuse reads by loads allowed only with enhanced option on.
// - device without enhanced set breaks on trapped opcode and warns host.
// - ignored or application-section store still breaks about 1.1 ms.
// - boot-lock interrupt disable ignored; vectors never move to boot section.
// - one vector table, two program words per vector, for both variants.
`timescale 1ns/1ps
module eot_trap (
	// clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        resetn_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// core side
	input  wire logic [3:0]  op_class_i,
	input  wire logic        op_valid_i,
	input  wire logic [15:0] pc_i,
	input  wire logic        fetch_i,
	input  wire logic [7:0]  spm_ctl_i,
	input  wire logic        spm_ignored_i,
	input  wire logic        xmem_req_i,
	input  wire logic        lock_read_i,
	input  wire logic [5:0]  vec_num_i,
	output logic             core_halt_o,
	output logic             io_clk_en_o,
	output logic             advance_pc_o,
	output logic             xmem_stall_o,
	output logic             lock_read_ok_o,
	output logic             irq_allow_o,
	output logic      [15:0] vec_addr_o,
	// interrupt
	output logic             irq_o
);
	eot_pkg::eot_state_t state;
	eot_pkg::eot_state_t next_state;
	logic [2:0]  ctrl;
	logic [eot_pkg::ST_BITS-1:0] status;
	logic [eot_pkg::ST_BITS-1:0] mask;
	logic [3:0]  cause;
	logic [19:0] cnt;
	logic        xmem_wait;
	logic        addr0_seen;

	wire enh_en     = ctrl[eot_pkg::CTRL_ENH];
	wire fuse_boot0 = ~ctrl[eot_pkg::CTRL_BOOTRSTF];
	wire no_enh_dev = ctrl[eot_pkg::CTRL_NOENHDEV];
	wire apb_wr     = psel_i & penable_i & pwrite_i;
	wire wr_ctrl    = apb_wr & (paddr_i == eot_pkg::REG_CTRL);
	wire wr_status  = apb_wr & (paddr_i == eot_pkg::REG_STATUS);
	wire wr_mask    = apb_wr & (paddr_i == eot_pkg::REG_MASK);
	wire sup_done   = wr_ctrl & pwdata_i[eot_pkg::CTRL_DONE];
	wire mapped     = (paddr_i == eot_pkg::REG_CTRL) | (paddr_i == eot_pkg::REG_STATUS) |
	                  (paddr_i == eot_pkg::REG_MASK) | (paddr_i == eot_pkg::REG_CAUSE);

	// operand-free loads are trapped only when the enhanced option is on
	wire is_plain_load = (op_class_i == 4'(eot_pkg::EOT_OP_LOAD0)) |
	                     (op_class_i == 4'(eot_pkg::EOT_OP_ELOAD0));
	wire is_enh_op = (op_class_i != 4'(eot_pkg::EOT_OP_NONE)) & ~is_plain_load;
	wire trap_op = op_valid_i & ((is_enh_op & (enh_en | no_enh_dev)) |
	                             (is_plain_load & enh_en));
	wire warn_ev  = op_valid_i & is_enh_op & no_enh_dev;
	wire addr0_ev = fetch_i & fuse_boot0 & (pc_i == eot_pkg::ADDR_ZERO) & ~addr0_seen;
	wire start    = (state == eot_pkg::EOT_ST_RUN) & (trap_op | addr0_ev);

	// break length in cycles of core_clk_i, the target core clock
	logic [19:0] brk_len;
	always_comb begin
		unique case (op_class_i)
			4'(eot_pkg::EOT_OP_WMOVE):     brk_len = 20'(eot_pkg::T_WORD_MOVE_US * eot_pkg::CYC_PER_US);
			4'(eot_pkg::EOT_OP_LOAD0),
			4'(eot_pkg::EOT_OP_LOAD):      brk_len = 20'(eot_pkg::T_LOAD_US * eot_pkg::CYC_PER_US);
			4'(eot_pkg::EOT_OP_LOAD_INC):  brk_len = 20'(eot_pkg::T_LOAD_INC_US * eot_pkg::CYC_PER_US);
			4'(eot_pkg::EOT_OP_ELOAD0),
			4'(eot_pkg::EOT_OP_ELOAD):     brk_len = 20'(eot_pkg::T_ELOAD_US * eot_pkg::CYC_PER_US);
			4'(eot_pkg::EOT_OP_ELOAD_INC): brk_len = 20'(eot_pkg::T_ELOAD_INC_US * eot_pkg::CYC_PER_US);
			4'(eot_pkg::EOT_OP_MUL):       brk_len = 20'(eot_pkg::T_MUL_US * eot_pkg::CYC_PER_US);
			4'(eot_pkg::EOT_OP_SPM): begin
				if (spm_ignored_i)
					brk_len = 20'(eot_pkg::T_SPM_IGN_US * eot_pkg::CYC_PER_US);
				else if (spm_ctl_i == eot_pkg::SPM_CTL_ERASE)
					brk_len = 20'(eot_pkg::T_SPM3_US * eot_pkg::CYC_PER_US);
				else if (spm_ctl_i == eot_pkg::SPM_CTL_WRITE)
					brk_len = 20'(eot_pkg::T_SPM5_US * eot_pkg::CYC_PER_US);
				else if (spm_ctl_i == eot_pkg::SPM_CTL_LOCK)
					brk_len = 20'(eot_pkg::T_SPM9_US * eot_pkg::CYC_PER_US);
				else
					brk_len = 20'(eot_pkg::T_SPM1_US * eot_pkg::CYC_PER_US);
			end
			default:                       brk_len = 20'(eot_pkg::T_ADDR0_US * eot_pkg::CYC_PER_US);
		endcase
	end

	// the break ends only when the timer ran out and the supervisor is done
	always_comb begin
		next_state = state;
		unique case (state)
			eot_pkg::EOT_ST_RUN:   if (start) next_state = eot_pkg::EOT_ST_BREAK;
			eot_pkg::EOT_ST_BREAK: if (cnt == 20'h00001) next_state = eot_pkg::EOT_ST_WAIT;
			eot_pkg::EOT_ST_WAIT:  if (sup_done) next_state = eot_pkg::EOT_ST_RUN;
			default:               next_state = eot_pkg::EOT_ST_RUN;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			state <= eot_pkg::EOT_ST_RUN;
			cnt   <= 20'h00000;
		end else begin
			state <= next_state;
			if (start)
				cnt <= addr0_ev & ~trap_op ? 20'(eot_pkg::T_ADDR0_US * eot_pkg::CYC_PER_US) : brk_len;
			else if (cnt != 20'h00000)
				cnt <= cnt - 20'h00001;
		end
	end

	// address-zero break fires once per arrival, re-armed once pc leaves zero
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i)
			addr0_seen <= 1'b0;
		else if (fetch_i)
			addr0_seen <= (pc_i == eot_pkg::ADDR_ZERO);
	end

	// one extra internal cycle per external data memory access
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i)
			xmem_wait <= 1'b0;
		else
			xmem_wait <= xmem_req_i & ~xmem_wait;
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			ctrl  <= eot_pkg::CTRL_RESET;
			mask  <= '0;
			cause <= 4'h0;
		end else begin
			if (wr_ctrl)
				ctrl <= pwdata_i[2:0];
			if (wr_mask)
				mask <= pwdata_i[eot_pkg::ST_BITS-1:0];
			if (start)
				cause <= addr0_ev & ~trap_op ? 4'hF : op_class_i;
		end
	end

	// set wins over a write-one clear in the same cycle
	wire [eot_pkg::ST_BITS-1:0] ev = {start & addr0_ev & ~trap_op, warn_ev & start, start};
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i)
			status <= '0;
		else
			status <= (status & ~(wr_status ? pwdata_i[eot_pkg::ST_BITS-1:0] : '0)) | ev;
	end

	wire halted = (state != eot_pkg::EOT_ST_RUN);
	assign core_halt_o    = halted | start;
	assign io_clk_en_o    = ~core_halt_o;
	assign advance_pc_o   = (state == eot_pkg::EOT_ST_WAIT) & sup_done &
	                        (cause != 4'hF);
	assign xmem_stall_o   = xmem_req_i & ~xmem_wait;
	assign lock_read_ok_o = lock_read_i & enh_en;
	assign irq_allow_o    = 1'b1;
	assign vec_addr_o     = 16'(vec_num_i) * 16'(eot_pkg::VEC_WORDS);
	assign irq_o          = |(status & mask);
	assign pready_o       = 1'b1;
	assign pslverr_o      = psel_i & penable_i & ~mapped;

	wire [31:0] rd_mux =
		(paddr_i == eot_pkg::REG_CTRL)   ? {29'h0, ctrl} :
		(paddr_i == eot_pkg::REG_STATUS) ? {29'h0, status} :
		(paddr_i == eot_pkg::REG_MASK)   ? {29'h0, mask} :
		(paddr_i == eot_pkg::REG_CAUSE)  ? {28'h0, cause} : 32'h0;
	assign prdata_o = rd_mux;
endmodule : eot_trap

// [bench/eot_trap_assertions.sv]
// eot_trap_assertions: port-level checks for eot_trap, bound below.
// assumes ctrl bits change only through apb writes to offset 0x00.
`timescale 1ns/1ps
module eot_trap_assertions (
	input wire logic        core_clk_i,
	input wire logic        resetn_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0]  op_class_i,
	input wire logic        op_valid_i,
	input wire logic [15:0] pc_i,
	input wire logic        xmem_req_i,
	input wire logic        lock_read_i,
	input wire logic        core_halt_o,
	input wire logic        io_clk_en_o,
	input wire logic        advance_pc_o,
	input wire logic        xmem_stall_o,
	input wire logic        lock_read_ok_o
);
	wire         wr_ctrl = psel_i && penable_i && pwrite_i && paddr_i == 8'h00;
	wire         done_w  = wr_ctrl && pwdata_i[3];
	logic        enh;
	logic        nodev;
	logic [19:0] cnt;
	logic [19:0] min_cyc;
	// shortest legal break: the word-move length for class 1, else the address-zero length, taken as the halt rises
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i || wr_ctrl) begin
			enh   <= resetn_i & pwdata_i[0];
			nodev <= resetn_i & pwdata_i[2];
		end
		cnt <= core_halt_o ? cnt + 20'h1 : 20'h0;
		if (core_halt_o && cnt == 20'h0) begin
			min_cyc <= (op_class_i == 4'h1) ? 20'h109A0 : 20'h03E80;
		end
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);
	io_clk_a: assert property (io_clk_en_o == !core_halt_o)
		else $error("io clock runs during a break");
	adv_done_a: assert property (advance_pc_o |-> done_w && $past(core_halt_o))
		else $error("advance without completion");
	break_min_a: assert property ($fell(core_halt_o) |-> cnt >= min_cyc)
		else $error("break ended too early");
	real_time_a: assert property
		(op_valid_i && !enh && !nodev && pc_i != 16'h0 && !$past(core_halt_o) |-> !core_halt_o)
		else $error("break with enhanced option off");
	trap_halt_a: assert property
		(op_valid_i && enh && op_class_i != 4'h0 && !$past(core_halt_o) |-> core_halt_o)
		else $error("trapped opcode ran on");
	lock_gate_a: assert property (lock_read_ok_o == (lock_read_i && enh))
		else $error("lock read gate wrong");
	xmem_extra_a: assert property ($rose(xmem_req_i) |-> xmem_stall_o ##1 !xmem_stall_o)
		else $error("external access stall wrong");
	halt_release_a: assert property ($fell(core_halt_o) |-> done_w || $past(done_w))
		else $error("halt dropped without completion");
	cover property ($rose(core_halt_o));
	cover property (advance_pc_o);
	cover property ($rose(xmem_req_i));
endmodule : eot_trap_assertions
bind eot_trap eot_trap_assertions u_chk (.core_clk_i, .resetn_i, .psel_i, .penable_i,
	.pwrite_i, .paddr_i, .pwdata_i, .op_class_i, .op_valid_i, .pc_i, .xmem_req_i,
	.lock_read_i, .core_halt_o, .io_clk_en_o, .advance_pc_o, .xmem_stall_o, .lock_read_ok_o);

// [bench/eot_core_model.sv]
// eot_core_model: target core side, fetches and issues opcodes on command.
// assumes core_halt_i freezes it; it waits up to 100 cycles for the halt to drop, then fetches.
`timescale 1ns/1ps
module eot_core_model (
	input  wire logic        core_clk_i,
	input  wire logic        core_halt_i,
	output logic      [3:0]  op_class_o,
	output logic             op_valid_o,
	output logic      [15:0] pc_o,
	output logic             fetch_o,
	output logic      [7:0]  spm_ctl_o,
	output logic             spm_ignored_o
);
	initial begin
		{op_class_o, op_valid_o, fetch_o, spm_ignored_o} = '0;
		pc_o      = 16'h0100;
		spm_ctl_o = 8'h05;
	end
	// trapped opcodes go out only when the bench asks for them
	task automatic issue(input logic [3:0] c, input logic [15:0] pc, input logic ign);
		int n;
		n = 0;
		while (core_halt_i !== 1'b0 && n < 100) begin
			@(posedge core_clk_i);
			n++;
		end
		if (n >= 100)
			testbench.err_total++;
		@(posedge core_clk_i);
		op_class_o    <= c;
		op_valid_o    <= c != 4'h0;
		fetch_o       <= 1'b1;
		pc_o          <= pc;
		spm_ignored_o <= ign;
		@(posedge core_clk_i);
		op_valid_o <= 1'b0;
		fetch_o    <= 1'b0;
		pc_o       <= ~pc;
	endtask : issue
endmodule : eot_core_model

// [bench/testbench.sv]
// testbench: drives eot_trap over apb and through the core model.
// assumes a 20 MHz clock; every wait is bounded.
`timescale 1ns/1ps
module testbench;
	logic        core_clk_i, resetn_i, psel_i, penable_i, pwrite_i, op_valid_i, fetch_i;
	logic        spm_ignored_i, xmem_req_i, lock_read_i, pready_o, pslverr_o, core_halt_o;
	logic        io_clk_en_o, advance_pc_o, xmem_stall_o, lock_read_ok_o, irq_allow_o, irq_o;
	logic [7:0]  paddr_i, spm_ctl_i;
	logic [31:0] pwdata_i, prdata_o, q;
	logic [3:0]  op_class_i;
	logic [15:0] pc_i, vec_addr_o;
	logic [5:0]  vec_num_i;
	logic        e, adv;
	int          err_total, n_compared;
	eot_trap i_dut (.core_clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
		.pwdata_i, .prdata_o, .pready_o, .pslverr_o, .op_class_i, .op_valid_i, .pc_i,
		.fetch_i, .spm_ctl_i, .spm_ignored_i, .xmem_req_i, .lock_read_i, .vec_num_i,
		.core_halt_o, .io_clk_en_o, .advance_pc_o, .xmem_stall_o, .lock_read_ok_o,
		.irq_allow_o, .vec_addr_o, .irq_o);
	eot_core_model i_core (.core_clk_i, .core_halt_i(core_halt_o), .op_class_o(op_class_i),
		.op_valid_o(op_valid_i), .pc_o(pc_i), .fetch_o(fetch_i), .spm_ctl_o(spm_ctl_i),
		.spm_ignored_o(spm_ignored_i));
	always #25 core_clk_i = ~core_clk_i;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("Error t=%0t got %0h exp %0h", $time, got, exp);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		logic ok;
		@(posedge core_clk_i);
		{psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		n = 0;
		ok = 1'b0;
		// answer is read while settled, just ahead of the edge that takes it
		do begin
			@(negedge core_clk_i);
			ok = (pready_o === 1'b1);
			{q, e, adv} = {prdata_o, pslverr_o, advance_pc_o};
			@(posedge core_clk_i);
			n++;
		end while (!ok && n < 16);
		if (!ok) begin
			err_total++;
			report_and_stop();
		end
		{psel_i, penable_i} <= 2'b00;
	endtask : apb
	task automatic t_reset();
		apb(1'b0, 8'h00, 32'h0);
		chk(q, 32'h2);
		chk({core_halt_o, io_clk_en_o, irq_o, irq_allow_o}, 4'h5);
		apb(1'b0, 8'h10, 32'h0);
		chk({e, q[30:0]}, 32'h80000000);
	endtask : t_reset
	task automatic t_misc();
		for (int v = 0; v < 64; v += 21) begin
			@(posedge core_clk_i);
			vec_num_i <= 6'(v);
			#1 chk(vec_addr_o, 32'(2 * v));
		end
		@(posedge core_clk_i);
		{xmem_req_i, lock_read_i} <= 2'b11;
		#1 chk(xmem_stall_o, 1'b1);
		@(posedge core_clk_i);
		#1 chk({xmem_stall_o, lock_read_ok_o}, 2'b00);
		@(posedge core_clk_i);
		xmem_req_i <= 1'b0;
		apb(1'b1, 8'h00, 32'h3);
		#1 chk(lock_read_ok_o, 1'b1);
	endtask : t_misc
	task automatic t_realtime();
		apb(1'b1, 8'h00, 32'h2);
		i_core.issue(4'h2, 16'h0100, 1'b0);
		#1 chk(core_halt_o, 1'b0);
		i_core.issue(4'h5, 16'h0102, 1'b0);
		#1 chk(core_halt_o, 1'b0);
	endtask : t_realtime
	// an early completion, written just before the timer runs out, must be ignored and keep the core halted
	task automatic run_break(input logic [31:0] c, input logic [3:0] cls, input logic [15:0] pc,
			input logic ign, input int n, input logic [31:0] b, input logic [31:0] cause,
			input logic adv_e);
		apb(1'b1, 8'h00, c);
		i_core.issue(cls, pc, ign);
		#1 chk({core_halt_o, io_clk_en_o}, 2'b10);
		repeat (n - 12) @(posedge core_clk_i);
		apb(1'b1, 8'h00, c | 32'h8);
		#1 chk(core_halt_o, 1'b1);
		repeat (20) @(posedge core_clk_i);
		apb(1'b0, 8'h0C, 32'h0);
		chk(q, cause);
		apb(1'b0, 8'h04, 32'h0);
		chk(q & b, b);
		apb(1'b1, 8'h08, b);
		#1 chk(irq_o, 1'b1);
		apb(1'b1, 8'h00, c | 32'h8);
		chk(adv, adv_e);
		#1 chk({core_halt_o, io_clk_en_o}, 2'b01);
		apb(1'b1, 8'h04, 32'h7);
		#1 chk(irq_o, 1'b0);
	endtask : run_break
	initial begin
		{core_clk_i, resetn_i, psel_i, penable_i, pwrite_i, xmem_req_i, lock_read_i} = '0;
		{paddr_i, pwdata_i, vec_num_i} = '0;
		{err_total, n_compared} = '0;
		repeat (4) @(posedge core_clk_i);
		resetn_i <= 1'b1;
		t_reset();
		t_misc();
		t_realtime();
		run_break(32'h3, 4'h1, 16'h0100, 1'b0, 68000, 32'h1, 32'h1, 1'b1);
		run_break(32'h0, 4'h0, 16'h0000, 1'b0, 16000, 32'h4, 32'hF, 1'b0);
		run_break(32'h6, 4'h9, 16'h0100, 1'b1, 22000, 32'h2, 32'h9, 1'b1);
		report_and_stop();
	end
endmodule : testbench
